// ===== src/isr_regs.vh
// Purpose: shared constants for the instrument status reporting block
// Assumes: included by bare name from every design file except the generic event register
// Notes:   definitions only
`ifndef ISR_REGS_VH
`define ISR_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// mask write selectors (cfg_sel)
`define ISR_CFG_SRE        4'h0
`define ISR_CFG_ESE        4'h1
`define ISR_CFG_OP_EN      4'h2
`define ISR_CFG_OP_PTR     4'h3
`define ISR_CFG_OP_NTR     4'h4
`define ISR_CFG_SQ_EN      4'h5
`define ISR_CFG_SQ_PTR     4'h6
`define ISR_CFG_SQ_NTR     4'h7

////////////////////////////////////////////////////////////////////////////////
// read selectors (rd_sel)
`define ISR_RD_STB         4'h0
`define ISR_RD_SPOLL       4'h1
`define ISR_RD_ESR         4'h2
`define ISR_RD_OP_EVT      4'h3
`define ISR_RD_OP_COND     4'h4
`define ISR_RD_SQ_EVT      4'h5
`define ISR_RD_SQ_COND     4'h6
`define ISR_RD_SRE         4'h7
`define ISR_RD_ESE         4'h8
`define ISR_RD_OP_EN       4'h9
`define ISR_RD_SQ_EN       4'hA

////////////////////////////////////////////////////////////////////////////////
// status byte bit positions
`define ISR_STB_SQ         3
`define ISR_STB_MAV        4
`define ISR_STB_ESB        5
`define ISR_STB_RQS        6
`define ISR_STB_OP         7

// operation-condition bit positions
`define ISR_OP_SETTLE      1
`define ISR_OP_RANGE       2
`define ISR_OP_MEAS        4
`define ISR_OP_PROC        9
`define ISR_OP_HCOPY       10
`define ISR_OP_AVG         11

// signal-quality bit positions
`define ISR_SQ_POWER       3
`define ISR_SQ_MAXSIG      9
`define ISR_SQ_DRIFT       10
`define ISR_SQ_DELTA       11
`define ISR_SQ_CMDWARN     14

////////////////////////////////////////////////////////////////////////////////
// widths, used-bit masks and reset values
`define ISR_OP_W           17
`define ISR_SQ_W           16
`define ISR_OP_USED        17'h00E16
`define ISR_SQ_USED        16'h4E08
`define ISR_SRE_RST        8'h00
`define ISR_ESE_RST        8'h00
`define ISR_ESR_RST        8'h80
`define ISR_OP_EN_RST      17'h00000
`define ISR_OP_PTR_RST     17'h1FFFF
`define ISR_OP_NTR_RST     17'h00000
`define ISR_SQ_EN_RST      16'h0000
`define ISR_SQ_PTR_RST     16'hFFFF
`define ISR_SQ_NTR_RST     16'h0000

`endif

// ===== src/isr_evt_reg.v
// Purpose: condition / transition filter / event / enable register group
// Assumes: cond_in is on clk_sys, one-cycle strobes for writes and clears
// Notes:   unused positions are forced to zero, except that the enable and filter reset values load unmasked
`timescale 1ns/100ps
`default_nettype none
module isr_evt_reg #(
  parameter             WIDTH   = 16,
  parameter [WIDTH-1:0] USED    = {WIDTH{1'b1}},
  parameter [WIDTH-1:0] EN_RST  = {WIDTH{1'b0}},
  parameter [WIDTH-1:0] PTR_RST = {WIDTH{1'b1}},
  parameter [WIDTH-1:0] NTR_RST = {WIDTH{1'b0}}
) (
  input  wire             clk_sys,
  input  wire             rstn,
  input  wire [WIDTH-1:0] cond_in,
  input  wire             en_wr,
  input  wire             ptr_wr,
  input  wire             ntr_wr,
  input  wire [WIDTH-1:0] wr_data,
  input  wire             rd_clr,
  input  wire             cls,
  output wire [WIDTH-1:0] cond_out,
  output wire [WIDTH-1:0] event_out,
  output wire [WIDTH-1:0] enable_out,
  output wire             summary
);

  reg  [WIDTH-1:0] cond_reg;
  reg  [WIDTH-1:0] evt_reg;
  reg  [WIDTH-1:0] en_reg;
  reg  [WIDTH-1:0] ptr_reg;
  reg  [WIDTH-1:0] ntr_reg;
  wire [WIDTH-1:0] cond_now;
  wire [WIDTH-1:0] hits;

  assign cond_now = cond_in & USED;
  assign hits     = (ptr_reg & cond_now & ~cond_reg) |
                    (ntr_reg & ~cond_now & cond_reg);

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys) begin
    if (!rstn) begin
      cond_reg <= {WIDTH{1'b0}};
      evt_reg  <= {WIDTH{1'b0}};
      en_reg   <= EN_RST;
      ptr_reg  <= PTR_RST;
      ntr_reg  <= NTR_RST;
    end else begin
      cond_reg <= cond_now;
      // set beats a same-cycle read or clear, so no edge is lost
      if (rd_clr || cls) begin
        evt_reg <= hits;
      end else begin
        evt_reg <= evt_reg | hits;
      end
      if (en_wr) begin
        en_reg <= wr_data & USED;
      end
      if (ptr_wr) begin
        ptr_reg <= wr_data & USED;
      end
      if (ntr_wr) begin
        ntr_reg <= wr_data & USED;
      end
    end
  end

  assign cond_out   = cond_reg;
  assign event_out  = evt_reg;
  assign enable_out = en_reg;
  assign summary    = |(evt_reg & en_reg & USED);

endmodule // isr_evt_reg
`default_nettype wire

// ===== src/isr_std_evt.v
// Purpose: standard event register with its enable mask
// Assumes: set_in bits are one-cycle event pulses on clk_sys
// Notes:   power-on bit comes up set out of reset
`timescale 1ns/100ps
`default_nettype none
`include "isr_regs.vh"
module isr_std_evt (
  input  wire       clk_sys,
  input  wire       rstn,
  input  wire [7:0] set_in,
  input  wire       ese_wr,
  input  wire [7:0] wr_data,
  input  wire       rd_clr,
  input  wire       cls,
  output wire [7:0] esr_out,
  output wire [7:0] ese_out,
  output wire       summary
);

  reg [7:0] esr_reg;
  reg [7:0] ese_reg;

  always @(posedge clk_sys) begin
    if (!rstn) begin
      esr_reg <= `ISR_ESR_RST;
      ese_reg <= `ISR_ESE_RST;
    end else begin
      if (rd_clr || cls) begin
        esr_reg <= set_in;
      end else begin
        esr_reg <= esr_reg | set_in;
      end
      if (ese_wr) begin
        ese_reg <= wr_data;
      end
    end
  end

  assign esr_out = esr_reg;
  assign ese_out = ese_reg;
  // disabled bits still latch, they just stay out of the summary
  assign summary = |(esr_reg & ese_reg);

endmodule // isr_std_evt
`default_nettype wire

// ===== src/isr_top.v
// Purpose: status byte, summary and service-request logic of the instrument
// Assumes: all inputs come from logic on clk_sys, strobes are one cycle wide
// Notes:   reads answer one cycle after rd_req on rd_valid / rd_data
//
// Overview of operation
// - status byte bits follow their summary sources
// - summary bits are OR of register bits
// - byte read returns binary weighted sum
// - serial poll reports and clears request-service bit
// - query reports master summary, leaves request alone
// - positive filter catches false-to-true changes
// - negative filter catches true-to-false changes
// - operation bit 1 while motor settles
// - operation bit 2 while gain ranging
// - operation bit 4 while measuring
// - operation bit 9 while processing data
// - operation bit 10 while printing hardcopy
// - operation bit 11 while averaging noise
// - quality bit 3 on excessive power
// - quality bit 9 at maximum signal count
// - quality bit 10 on drift count mismatch
// - quality bit 11 when no delta reference
// - quality bit 14 on extra command parameters
// - enabled standard events set status bit 5
// - status bit 4 while output queue nonempty
// - enabled bit 5 raises service request
// - clear status empties events, keeps output queue
`timescale 1ns/100ps
`default_nettype none
`include "isr_regs.vh"
module isr_top (
  input  wire                   clk_sys,
  input  wire                   rstn,
  // operation conditions
  input  wire                   motor_settle_flag,
  input  wire                   gain_ranging,
  input  wire                   measuring,
  input  wire                   processing,
  input  wire                   hardcopy,
  input  wire                   averaging,
  // signal-quality conditions
  input  wire                   power_high,
  input  wire                   max_signals,
  input  wire                   drift_ref_mismatch,
  input  wire                   delta_ref_missing,
  input  wire                   cmd_warning,
  // standard events and output queue
  input  wire [7:0]             std_event_set,
  input  wire                   out_queue_nonempty,
  // mask writes
  input  wire                   cfg_wr,
  input  wire [3:0]             cfg_sel,
  input  wire [`ISR_OP_W-1:0]   cfg_data,
  // reads
  input  wire                   rd_req,
  input  wire [3:0]             rd_sel,
  input  wire                   clear_status,
  output reg                    rd_valid,
  output reg  [`ISR_OP_W-1:0]   rd_data,
  output wire [7:0]             status_byte,
  output wire                   srq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // decoding shared by writes and clearing reads
  function sel_hit;
    input       strobe;
    input [3:0] sel;
    input [3:0] code;
    begin
      sel_hit = strobe && (sel == code);
    end
  endfunction

  wire [`ISR_OP_W-1:0] op_cond;
  wire [`ISR_SQ_W-1:0] sq_cond;
  wire [`ISR_OP_W-1:0] op_cond_q;
  wire [`ISR_OP_W-1:0] op_evt;
  wire [`ISR_OP_W-1:0] op_en;
  wire [`ISR_SQ_W-1:0] sq_cond_q;
  wire [`ISR_SQ_W-1:0] sq_evt;
  wire [`ISR_SQ_W-1:0] sq_en;
  wire [7:0]           esr;
  wire [7:0]           ese;
  wire                 op_sum;
  wire                 sq_sum;
  wire                 esb_sum;
  wire                 sre_wr;
  wire                 ese_wr;
  wire                 op_en_wr;
  wire                 op_ptr_wr;
  wire                 op_ntr_wr;
  wire                 sq_en_wr;
  wire                 sq_ptr_wr;
  wire                 sq_ntr_wr;
  wire                 esr_rd;
  wire                 op_evt_rd;
  wire                 sq_evt_rd;
  wire                 spoll_rd;
  wire                 mss;
  wire [7:0]           stb_core;
  wire [7:0]           sre_bit_mask;
  reg  [7:0]           sre_reg;
  reg                  rqs_reg;
  reg                  rqs_next;
  reg                  mss_prev_reg;
  reg  [`ISR_OP_W-1:0] rd_next;

  ////////////////////////////////////////////////////////////////////////////
  // write strobes and event-clearing reads, decoded once here
  // so every selector compare has a single named driver
  assign sre_wr    = sel_hit(cfg_wr, cfg_sel, `ISR_CFG_SRE);
  assign ese_wr    = sel_hit(cfg_wr, cfg_sel, `ISR_CFG_ESE);
  assign op_en_wr  = sel_hit(cfg_wr, cfg_sel, `ISR_CFG_OP_EN);
  assign op_ptr_wr = sel_hit(cfg_wr, cfg_sel, `ISR_CFG_OP_PTR);
  assign op_ntr_wr = sel_hit(cfg_wr, cfg_sel, `ISR_CFG_OP_NTR);
  assign sq_en_wr  = sel_hit(cfg_wr, cfg_sel, `ISR_CFG_SQ_EN);
  assign sq_ptr_wr = sel_hit(cfg_wr, cfg_sel, `ISR_CFG_SQ_PTR);
  assign sq_ntr_wr = sel_hit(cfg_wr, cfg_sel, `ISR_CFG_SQ_NTR);
  assign esr_rd    = sel_hit(rd_req, rd_sel, `ISR_RD_ESR);
  assign op_evt_rd = sel_hit(rd_req, rd_sel, `ISR_RD_OP_EVT);
  assign sq_evt_rd = sel_hit(rd_req, rd_sel, `ISR_RD_SQ_EVT);

  ////////////////////////////////////////////////////////////////////////////
  // condition vectors
  assign op_cond = {{(`ISR_OP_W-12){1'b0}},
                    averaging,
                    hardcopy,
                    processing,
                    4'h0,
                    measuring,
                    1'b0,
                    gain_ranging,
                    motor_settle_flag,
                    1'b0};
  assign sq_cond = {1'b0,
                    cmd_warning,
                    2'h0,
                    delta_ref_missing,
                    drift_ref_mismatch,
                    max_signals,
                    5'h00,
                    power_high,
                    3'h0};

  ////////////////////////////////////////////////////////////////////////////
  isr_evt_reg #(
    .WIDTH   (`ISR_OP_W),
    .USED    (`ISR_OP_USED),
    .EN_RST  (`ISR_OP_EN_RST),
    .PTR_RST (`ISR_OP_PTR_RST),
    .NTR_RST (`ISR_OP_NTR_RST)
  ) u_op (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .cond_in    (op_cond),
    .en_wr      (op_en_wr),
    .ptr_wr     (op_ptr_wr),
    .ntr_wr     (op_ntr_wr),
    .wr_data    (cfg_data),
    .rd_clr     (op_evt_rd),
    .cls        (clear_status),
    .cond_out   (op_cond_q),
    .event_out  (op_evt),
    .enable_out (op_en),
    .summary    (op_sum)
  );

  isr_evt_reg #(
    .WIDTH   (`ISR_SQ_W),
    .USED    (`ISR_SQ_USED),
    .EN_RST  (`ISR_SQ_EN_RST),
    .PTR_RST (`ISR_SQ_PTR_RST),
    .NTR_RST (`ISR_SQ_NTR_RST)
  ) u_sq (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .cond_in    (sq_cond),
    .en_wr      (sq_en_wr),
    .ptr_wr     (sq_ptr_wr),
    .ntr_wr     (sq_ntr_wr),
    .wr_data    (cfg_data[`ISR_SQ_W-1:0]),
    .rd_clr     (sq_evt_rd),
    .cls        (clear_status),
    .cond_out   (sq_cond_q),
    .event_out  (sq_evt),
    .enable_out (sq_en),
    .summary    (sq_sum)
  );

  isr_std_evt u_std (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .set_in  (std_event_set),
    .ese_wr  (ese_wr),
    .wr_data (cfg_data[7:0]),
    .rd_clr  (esr_rd),
    .cls     (clear_status),
    .esr_out (esr),
    .ese_out (ese),
    .summary (esb_sum)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status byte: combinational on the summaries, so bits drop with them
  assign stb_core = {op_sum,
                     1'b0,
                     esb_sum,
                     out_queue_nonempty,
                     sq_sum,
                     3'h0};
  // bit 6 of the service-request mask has no meaning
  assign sre_bit_mask = 8'hBF;
  assign mss          = |(stb_core & sre_reg & sre_bit_mask);
  assign spoll_rd     = sel_hit(rd_req, rd_sel, `ISR_RD_SPOLL);

  // request fires on a new reason for service; a fresh reason in the poll
  // cycle survives the clear so the controller is not left unaware
  always @* begin
    rqs_next = rqs_reg;
    if (spoll_rd) begin
      rqs_next = 1'b0;
    end
    if (mss && !mss_prev_reg) begin
      rqs_next = 1'b1;
    end
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      sre_reg      <= `ISR_SRE_RST;
      rqs_reg      <= 1'b0;
      mss_prev_reg <= 1'b0;
    end else begin
      rqs_reg      <= rqs_next;
      mss_prev_reg <= mss;
      if (sre_wr) begin
        sre_reg <= cfg_data[7:0] & sre_bit_mask;
      end
    end
  end

  assign status_byte = stb_core | {1'b0, mss, 6'h00};
  assign srq_out     = rqs_reg;

  ////////////////////////////////////////////////////////////////////////////
  // read port: each value is its own binary weighted sum
  always @* begin
    rd_next = {`ISR_OP_W{1'b0}};
    case (rd_sel)
      `ISR_RD_STB: begin
        rd_next[7:0] = stb_core | {1'b0, mss, 6'h00};
      end
      `ISR_RD_SPOLL: begin
        rd_next[7:0] = stb_core | {1'b0, rqs_reg, 6'h00};
      end
      `ISR_RD_ESR: begin
        rd_next[7:0] = esr;
      end
      `ISR_RD_OP_EVT: begin
        rd_next = op_evt;
      end
      `ISR_RD_OP_COND: begin
        rd_next = op_cond_q;
      end
      `ISR_RD_SQ_EVT: begin
        rd_next[`ISR_SQ_W-1:0] = sq_evt;
      end
      `ISR_RD_SQ_COND: begin
        rd_next[`ISR_SQ_W-1:0] = sq_cond_q;
      end
      `ISR_RD_SRE: begin
        rd_next[7:0] = sre_reg;
      end
      `ISR_RD_ESE: begin
        rd_next[7:0] = ese;
      end
      `ISR_RD_OP_EN: begin
        rd_next = op_en;
      end
      `ISR_RD_SQ_EN: begin
        rd_next[`ISR_SQ_W-1:0] = sq_en;
      end
      default: begin
        rd_next = {`ISR_OP_W{1'b0}};
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      rd_valid <= 1'b0;
      rd_data  <= {`ISR_OP_W{1'b0}};
    end else begin
      rd_valid <= rd_req;
      if (rd_req) begin
        rd_data <= rd_next;
      end
    end
  end

endmodule // isr_top
`default_nettype wire

// ===== testbench/isr_top_asserts.sv
// Purpose: port-level checks of the status byte block
// Assumes: rstn synchronous, active low
// Notes:   bound to every isr_top instance
`timescale 1ns/100ps
`default_nettype none
`include "isr_regs.vh"
module isr_top_asserts (
  input wire logic                   clk_sys,
  input wire logic                   rstn,
  input wire logic                   out_queue_nonempty,
  input wire logic                   rd_req,
  input wire logic [3:0]             rd_sel,
  input wire logic                   rd_valid,
  input wire logic [`ISR_OP_W-1:0]   rd_data,
  input wire logic [7:0]             status_byte,
  input wire logic                   srq_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  AST_RD_ANSWER: assert property (rd_req |=> rd_valid)
    else $error("read not answered");
  AST_RD_QUIET: assert property (!rd_req |=> !rd_valid)
    else $error("valid without read");
  AST_STB_DATA: assert property (rd_req && rd_sel == 4'h0 |=>
    rd_data == {9'h000, $past(status_byte)}) else $error("query value wrong");
  AST_STB_KEEP: assert property (rd_req && rd_sel == 4'h0 && srq_out |=> srq_out)
    else $error("query cleared request");
  AST_POLL_DATA: assert property (rd_req && rd_sel == 4'h1 |=> rd_data ==
    {9'h000, $past(status_byte[7]), $past(srq_out), $past(status_byte[5:0])})
    else $error("poll value wrong");
  AST_POLL_CLR: assert property (rd_req && rd_sel == 4'h1 && !$rose(status_byte[6])
    |=> !srq_out) else $error("poll kept request");
  AST_SRQ_RISE: assert property ($rose(srq_out) |->
    $past(status_byte[6]) && !$past(status_byte[6], 2)) else $error("request without cause");
  AST_SRQ_FALL: assert property ($fell(srq_out) |->
    $past(rd_req) && $past(rd_sel) == 4'h1) else $error("request dropped without poll");
  AST_MAV: assert property (status_byte[`ISR_STB_MAV] == out_queue_nonempty)
    else $error("message bit wrong");
  AST_COND_UNUSED: assert property (rd_req && rd_sel == 4'h4 |=>
    (rd_data & ~`ISR_OP_USED) == 17'h00000) else $error("unused bit set");
endmodule // isr_top_asserts
bind isr_top isr_top_asserts u_chk (.clk_sys(clk_sys), .rstn(rstn),
  .out_queue_nonempty(out_queue_nonempty), .rd_req(rd_req), .rd_sel(rd_sel),
  .rd_valid(rd_valid), .rd_data(rd_data), .status_byte(status_byte), .srq_out(srq_out));
`default_nettype wire

// ===== testbench/isr_host_model.sv
// Purpose: controller side issuing reads, mask writes and clears
// Assumes: requests change 1 ns after the rising edge
// Notes:   released selectors show the inverse, never the last value
`timescale 1ns/100ps
`default_nettype none
module isr_host_model (
  input  wire logic        clk_sys,
  input  wire logic        rd_valid,
  input  wire logic [16:0] rd_data,
  output var  logic        cfg_wr,
  output var  logic [3:0]  cfg_sel,
  output var  logic [16:0] cfg_data,
  output var  logic        rd_req,
  output var  logic [3:0]  rd_sel,
  output var  logic        clear_status
);
  initial begin
    cfg_wr = 1'b0;
    cfg_sel = 4'hF;
    cfg_data = 17'h00000;
    rd_req = 1'b0;
    rd_sel = 4'hF;
    clear_status = 1'b0;
  end
  task automatic wr(input logic [3:0] s, input logic [16:0] d);
    @(posedge clk_sys);
    #1;
    cfg_wr = 1'b1;
    cfg_sel = s;
    cfg_data = d;
    @(posedge clk_sys);
    #1;
    cfg_wr = 1'b0;
    cfg_sel = ~s;
    cfg_data = ~d;
  endtask
  // answer is due exactly one cycle after the request edge
  task automatic rd(input logic [3:0] s, output logic [16:0] q, output logic ok);
    @(posedge clk_sys);
    #1;
    rd_req = 1'b1;
    rd_sel = s;
    @(posedge clk_sys);
    #1;
    rd_req = 1'b0;
    rd_sel = ~s;
    ok = rd_valid;
    q = rd_data;
  endtask
  task automatic cls();
    @(posedge clk_sys);
    #1;
    clear_status = 1'b1;
    @(posedge clk_sys);
    #1;
    clear_status = 1'b0;
  endtask
endmodule // isr_host_model
`default_nettype wire

// ===== testbench/isr_top_bench.sv
// Purpose: self-checking bench of the status byte block
// Assumes: host model issues every read, write and clear
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/100ps
`default_nettype none
`include "isr_regs.vh"
module isr_top_bench;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic [5:0]  oper_c = 6'h00;
  logic [4:0]  qual_c = 5'h00;
  logic [7:0]  std_event_set = 8'h00;
  logic        out_queue_nonempty = 1'b0;
  wire         cfg_wr, rd_req, clear_status, rd_valid, srq_out;
  wire  [3:0]  cfg_sel, rd_sel;
  wire  [16:0] cfg_data, rd_data;
  wire  [7:0]  sb;
  int          fails = 0;
  int          compares = 0;
  int          op_pos [6] = '{1, 2, 4, 9, 10, 11};
  int          sq_pos [5] = '{3, 9, 10, 11, 14};

  always #2 clk_sys = ~clk_sys;

  isr_top uut (.clk_sys(clk_sys), .rstn(rstn), .motor_settle_flag(oper_c[0]),
    .gain_ranging(oper_c[1]), .measuring(oper_c[2]), .processing(oper_c[3]),
    .hardcopy(oper_c[4]), .averaging(oper_c[5]), .power_high(qual_c[0]),
    .max_signals(qual_c[1]), .drift_ref_mismatch(qual_c[2]), .delta_ref_missing(qual_c[3]),
    .cmd_warning(qual_c[4]), .std_event_set(std_event_set),
    .out_queue_nonempty(out_queue_nonempty), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel),
    .cfg_data(cfg_data), .rd_req(rd_req), .rd_sel(rd_sel), .clear_status(clear_status),
    .rd_valid(rd_valid), .rd_data(rd_data), .status_byte(sb), .srq_out(srq_out));
  isr_host_model host (.clk_sys(clk_sys), .rd_valid(rd_valid), .rd_data(rd_data),
    .cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_data(cfg_data), .rd_req(rd_req),
    .rd_sel(rd_sel), .clear_status(clear_status));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input string nm, input logic [3:0] s, input logic [16:0] e);
    logic [16:0] q;
    logic        ok;
    host.rd(s, q, ok);
    chk({nm, " valid"}, 17'h00001, {16'h0000, ok});
    chk(nm, e, q);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic conclude();
    $display("counts: compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("stb", 17'h00000, {9'h000, sb});
    rdc("sre", 4'h7, 17'h00000);
    rdc("ese", 4'h8, 17'h00000);
    rdc("esr", 4'h2, 17'h00080);
    rdc("esr again", 4'h2, 17'h00000);
    rdc("spare sel", 4'hF, 17'h00000);
    $display("test reset done");
  endtask
  task automatic t_cond(input bit q);
    int i;
    for (i = 0; i < (q ? 5 : 6); i++) begin
      if (q) qual_c = 5'h01 << i;
      else oper_c = 6'h01 << i;
      cyc(3);
      rdc("cond", q ? 4'h6 : 4'h4, 17'h00001 << (q ? sq_pos[i] : op_pos[i]));
      rdc("event", q ? 4'h5 : 4'h3, 17'h00001 << (q ? sq_pos[i] : op_pos[i]));
    end
    qual_c = 5'h00;
    oper_c = 6'h00;
    cyc(3);
    rdc("fall", q ? 4'h5 : 4'h3, 17'h00000);
    $display("test conditions done");
  endtask
  task automatic t_filt();
    host.wr(4'h3, 17'h00000);
    host.wr(4'h4, 17'h1FFFF);
    oper_c = 6'h04;
    cyc(3);
    rdc("rise ignored", 4'h3, 17'h00000);
    oper_c = 6'h00;
    cyc(3);
    rdc("fall seen", 4'h3, 17'h00010);
    host.wr(4'h3, 17'h1FFFF);
    host.wr(4'h4, 17'h00000);
    $display("test filters done");
  endtask
  task automatic t_ques();
    host.wr(4'h5, 17'h1FFFF);
    rdc("sq en", 4'hA, 17'h04E08);
    host.wr(4'h6, 17'h00000);
    host.wr(4'h7, 17'h1FFFF);
    qual_c = 5'h01;
    cyc(3);
    chk("sq rise ignored", 17'h00000, {16'h0000, sb[3]});
    qual_c = 5'h00;
    cyc(3);
    chk("sq summary", 17'h00001, {16'h0000, sb[3]});
    rdc("sq fall", 4'h5, 17'h00008);
    chk("sq summary cleared", 17'h00000, {16'h0000, sb[3]});
    host.wr(4'h6, 17'h1FFFF);
    host.wr(4'h7, 17'h00000);
    host.wr(4'h5, 17'h00000);
    $display("test quality summary done");
  endtask
  task automatic t_srq();
    host.wr(4'h2, 17'h1FFFF);
    rdc("op en", 4'h9, `ISR_OP_USED);
    host.wr(4'h0, 17'h000FF);
    rdc("sre", 4'h7, 17'h000BF);
    oper_c = 6'h10;
    cyc(3);
    chk("srq", 17'h00001, {16'h0000, srq_out});
    rdc("stb query", 4'h0, 17'h000C0);
    rdc("poll", 4'h1, 17'h000C0);
    chk("srq polled", 17'h00000, {16'h0000, srq_out});
    rdc("poll again", 4'h1, 17'h00080);
    host.wr(4'h2, 17'h00000);
    cyc(1);
    chk("masked", 17'h00000, {16'h0000, sb[7]});
    rdc("event kept", 4'h3, 17'h00400);
    oper_c = 6'h00;
    $display("test service request done");
  endtask
  task automatic t_esb();
    // only bit 5 enabled, so the message bit cannot raise the request
    host.wr(4'h0, 17'h00020);
    out_queue_nonempty = 1'b1;
    std_event_set = 8'h08;
    cyc(1);
    std_event_set = 8'h00;
    cyc(2);
    chk("esb off", 17'h00000, {16'h0000, sb[5]});
    chk("srq mav masked", 17'h00000, {16'h0000, srq_out});
    host.wr(4'h1, 17'h00008);
    cyc(1);
    chk("esb on", 17'h00001, {16'h0000, sb[5]});
    cyc(2);
    chk("srq esb", 17'h00001, {16'h0000, srq_out});
    host.cls();
    chk("esb cleared", 17'h00000, {16'h0000, sb[5]});
    chk("mav kept", 17'h00001, {16'h0000, sb[4]});
    rdc("esr cleared", 4'h2, 17'h00000);
    rdc("poll esb", 4'h1, 17'h00050);
    out_queue_nonempty = 1'b0;
    cyc(1);
    chk("mav off", 17'h00000, {16'h0000, sb[4]});
    $display("test standard events done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    t_reset();
    t_cond(1'b0);
    t_cond(1'b1);
    t_filt();
    t_ques();
    t_srq();
    t_esb();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    $display("unexpected run length: expected end seen hang");
    conclude();
  end
endmodule // isr_top_bench
`default_nettype wire
